// [verilog/rse_cfg.svh]
`ifndef RSE_CFG_SVH
`define RSE_CFG_SVH
// ****************************************
// widths and reset values
// ****************************************
`define RSE_DATA_W 8
`define RSE_ACC_RST 8'h00
`define RSE_WDT_RST 8'h00
`define RSE_PRE_RST 8'h00
`define RSE_WDT_W 8
`define RSE_PRE_W 8
`define RSE_MSB 7
`define RSE_NIB_MSB 3
// status flag reset values (power-down and expiry read 1 after power-up)
`define RSE_PD_RST 1'b1
`define RSE_TO_RST 1'b1
`define RSE_C_RST 1'b0
`define RSE_DC_RST 1'b0
`define RSE_Z_RST 1'b0
`endif

// [verilog/rse_pkg.sv]
package rse_pkg;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        RSE_OP_NONE,
        RSE_OP_ROTATE_LEFT,
        RSE_OP_ROTATE_RIGHT,
        RSE_OP_LITERAL_MINUS_ACC,
        RSE_OP_SLEEP
    } rse_op_type;
    typedef enum logic {
        RSE_RUN,
        RSE_ASLEEP
    } rse_state_type;
endpackage

// [verilog/rse_alu.sv]
`timescale 1ns/1ps
`include "rse_cfg.svh"
// ****************************************
// combinational result and flag unit
// ****************************************
module rse_alu (
    // operation and operands
    input wire rse_pkg::rse_op_type op_in,
    input wire logic [7:0] file_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] lit_in,
    input wire logic carry_in,
    // results
    output logic [7:0] result_out,
    output logic carry_out,
    output logic half_carry_out,
    output logic zero_out
);
    import rse_pkg::*;
    logic [8:0] diff;
    logic [4:0] ndiff;
    // result and flag selection per operation
    always_comb begin
        diff = {1'b0, lit_in} - {1'b0, acc_in};
        ndiff = {1'b0, lit_in[`RSE_NIB_MSB:0]} - {1'b0, acc_in[`RSE_NIB_MSB:0]};
        result_out = 8'h00;
        carry_out = carry_in;
        half_carry_out = 1'b0;
        zero_out = 1'b0;
        unique case (op_in)
            RSE_OP_ROTATE_LEFT: begin
                result_out = {file_in[`RSE_MSB-1:0], carry_in};
                carry_out = file_in[`RSE_MSB];
            end
            RSE_OP_ROTATE_RIGHT: begin
                result_out = {carry_in, file_in[`RSE_MSB:1]};
                carry_out = file_in[0];
            end
            RSE_OP_LITERAL_MINUS_ACC: begin
                result_out = diff[7:0];
                carry_out = ~diff[8];
                half_carry_out = ~ndiff[4];
                zero_out = (diff[7:0] == 8'h00);
            end
            default: begin
                result_out = 8'h00;
            end
        endcase
    end
endmodule

// [verilog/rse_exec.sv]
`timescale 1ns/1ps
`include "rse_cfg.svh"
module rse_exec (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // instruction
    input wire logic EXEC_IN,
    input wire rse_pkg::rse_op_type OP_IN,
    input wire logic DEST_FILE_IN,
    input wire logic [7:0] FILE_DATA_IN,
    input wire logic [7:0] LITERAL_IN,
    // watchdog advance and wake
    input wire logic WDT_TICK_IN,
    input wire logic WAKE_IN,
    // file write-back
    output logic FILE_WE_OUT,
    output logic [7:0] FILE_WDATA_OUT,
    // architectural state
    output logic [7:0] ACC_OUT,
    output logic CARRY_OUT,
    output logic HALF_CARRY_FLAG_OUT,
    output logic ZERO_OUT,
    output logic POWER_DOWN_FLAG_OUT,
    output logic WATCHDOG_EXPIRY_FLAG_OUT,
    // watchdog and power state
    output logic [7:0] WDT_COUNT_OUT,
    output logic [7:0] WDT_PRESCALE_OUT,
    output logic OSC_RUN_OUT,
    output logic ASLEEP_OUT
);
    import rse_pkg::*;
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        rse_state_type state;
        logic [7:0] acc;
        logic c;
        logic dc;
        logic z;
        logic pd;
        logic to;
        logic [7:0] wdt;
        logic [7:0] pre;
        logic fwe;
        logic [7:0] fdata;
    } rse_regs_type;
    rse_regs_type r_q;
    rse_regs_type r_d;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic issue;
    // ****************************************
    // datapath
    // ****************************************
    rse_alu u_alu (
        .op_in(OP_IN),
        .file_in(FILE_DATA_IN),
        .acc_in(r_q.acc),
        .lit_in(LITERAL_IN),
        .carry_in(r_q.c),
        .result_out(alu_res),
        .carry_out(alu_c),
        .half_carry_out(alu_dc),
        .zero_out(alu_z)
    );
    // instructions only execute while awake
    assign issue = EXEC_IN && (r_q.state == RSE_RUN);
    // next-state logic
    always_comb begin
        r_d = r_q;
        r_d.fwe = 1'b0;
        // free-running watchdog prescaler and count while awake
        if (r_q.state == RSE_RUN && WDT_TICK_IN) begin
            r_d.pre = r_q.pre + 8'h01;
            if (r_q.pre == 8'hFF) begin
                r_d.wdt = r_q.wdt + 8'h01;
            end
        end
        unique case (r_q.state)
            RSE_RUN: begin
                if (issue) begin
                    unique case (OP_IN)
                        RSE_OP_ROTATE_LEFT, RSE_OP_ROTATE_RIGHT: begin
                            r_d.c = alu_c;
                            if (DEST_FILE_IN) begin
                                r_d.fwe = 1'b1;
                                r_d.fdata = alu_res;
                            end else begin
                                r_d.acc = alu_res;
                            end
                        end
                        RSE_OP_LITERAL_MINUS_ACC: begin
                            r_d.acc = alu_res;
                            r_d.c = alu_c;
                            r_d.dc = alu_dc;
                            r_d.z = alu_z;
                        end
                        RSE_OP_SLEEP: begin
                            r_d.pd = 1'b0;
                            r_d.to = 1'b1;
                            r_d.wdt = `RSE_WDT_RST;
                            r_d.pre = `RSE_PRE_RST;
                            r_d.state = RSE_ASLEEP;
                        end
                        default: begin
                            r_d.fwe = 1'b0;
                        end
                    endcase
                end
            end
            RSE_ASLEEP: begin
                // oscillator stays stopped until woken
                if (WAKE_IN) begin
                    r_d.state = RSE_RUN;
                end
            end
        endcase
    end
    // state register
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            r_q.state <= RSE_RUN;
            r_q.acc <= `RSE_ACC_RST;
            r_q.c <= `RSE_C_RST;
            r_q.dc <= `RSE_DC_RST;
            r_q.z <= `RSE_Z_RST;
            r_q.pd <= `RSE_PD_RST;
            r_q.to <= `RSE_TO_RST;
            r_q.wdt <= `RSE_WDT_RST;
            r_q.pre <= `RSE_PRE_RST;
            r_q.fwe <= 1'b0;
            r_q.fdata <= 8'h00;
        end else begin
            r_q <= r_d;
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    assign FILE_WE_OUT = r_q.fwe;
    assign FILE_WDATA_OUT = r_q.fdata;
    assign ACC_OUT = r_q.acc;
    assign CARRY_OUT = r_q.c;
    assign HALF_CARRY_FLAG_OUT = r_q.dc;
    assign ZERO_OUT = r_q.z;
    assign POWER_DOWN_FLAG_OUT = r_q.pd;
    assign WATCHDOG_EXPIRY_FLAG_OUT = r_q.to;
    assign WDT_COUNT_OUT = r_q.wdt;
    assign WDT_PRESCALE_OUT = r_q.pre;
    assign OSC_RUN_OUT = (r_q.state == RSE_RUN);
    assign ASLEEP_OUT = (r_q.state == RSE_ASLEEP);
endmodule

// [testbench/rse_exec_props.sv]
`timescale 1ns/1ps
// ****************************************
// execute stage checker
// ****************************************
module rse_exec_props (
    // clock, reset and instruction
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic EXEC_IN,
    input wire rse_pkg::rse_op_type OP_IN,
    input wire logic DEST_FILE_IN,
    input wire logic [7:0] FILE_DATA_IN,
    input wire logic [7:0] LITERAL_IN,
    // results and state
    input wire logic FILE_WE_OUT,
    input wire logic [7:0] FILE_WDATA_OUT,
    input wire logic [7:0] ACC_OUT,
    input wire logic CARRY_OUT,
    input wire logic HALF_CARRY_FLAG_OUT,
    input wire logic ZERO_OUT,
    input wire logic POWER_DOWN_FLAG_OUT,
    input wire logic WATCHDOG_EXPIRY_FLAG_OUT,
    input wire logic [7:0] WDT_COUNT_OUT,
    input wire logic [7:0] WDT_PRESCALE_OUT,
    input wire logic OSC_RUN_OUT,
    input wire logic ASLEEP_OUT
);
    import rse_pkg::*;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // taken operations and expected values
    wire go = EXEC_IN && !ASLEEP_OUT;
    wire rl = go && OP_IN == RSE_OP_ROTATE_LEFT;
    wire rr = go && OP_IN == RSE_OP_ROTATE_RIGHT;
    wire sb = go && OP_IN == RSE_OP_LITERAL_MINUS_ACC;
    wire sl = go && OP_IN == RSE_OP_SLEEP;
    wire [7:0] rl_v = {FILE_DATA_IN[6:0], CARRY_OUT};
    wire [7:0] rr_v = {CARRY_OUT, FILE_DATA_IN[7:1]};
    wire [7:0] dif = LITERAL_IN - ACC_OUT;
    wire cge = ACC_OUT <= LITERAL_IN;
    wire hge = ACC_OUT[3:0] <= LITERAL_IN[3:0];
    // per-instruction checks
    rotl_carry_a: assert property (rl |=> CARRY_OUT == $past(FILE_DATA_IN[7])) else $error("rotl carry");
    rotl_acc_a: assert property (rl && !DEST_FILE_IN |=> ACC_OUT == $past(rl_v)) else $error("rotl acc");
    rotr_file_a: assert property (rr && DEST_FILE_IN |=> FILE_WDATA_OUT == $past(rr_v)) else $error("rotr");
    dest_keep_a: assert property ((rl || rr) && DEST_FILE_IN |=> FILE_WE_OUT && $stable(ACC_OUT)) else $error("dst");
    dest_acc_a: assert property ((rl || rr) && !DEST_FILE_IN |=> !FILE_WE_OUT) else $error("dest acc");
    sleep_flags_a: assert property (sl |=> !POWER_DOWN_FLAG_OUT && WATCHDOG_EXPIRY_FLAG_OUT) else $error("pd");
    sleep_wdt_a: assert property (sl |=> WDT_COUNT_OUT == 8'h00 && WDT_PRESCALE_OUT == 8'h00) else $error("wdt");
    sleep_halt_a: assert property (sl |=> ASLEEP_OUT && !OSC_RUN_OUT) else $error("halt");
    sub_result_a: assert property (sb |=> ACC_OUT == $past(dif) && CARRY_OUT == $past(cge)) else $error("sub");
    sub_half_a: assert property (sb |=> HALF_CARRY_FLAG_OUT == $past(hge)) else $error("sub half");
    sub_zero_a: assert property (sb |=> ZERO_OUT == (ACC_OUT == 8'h00)) else $error("sub zero");
endmodule

// [testbench/rse_exec_tb.sv]
`timescale 1ns/1ps
// ****************************************
// execute stage testbench
// ****************************************
module rse_exec_tb;
    import rse_pkg::*;
    logic CLK_IN = 1'b0, RSTN_IN = 1'b0, EXEC_IN = 1'b0, DEST_FILE_IN = 1'b0, WDT_TICK_IN = 1'b0, WAKE_IN = 1'b0;
    rse_op_type OP_IN = RSE_OP_NONE;
    logic [7:0] FILE_DATA_IN = 8'h00, LITERAL_IN = 8'h00, FILE_WDATA_OUT, ACC_OUT, WDT_COUNT_OUT, WDT_PRESCALE_OUT;
    logic FILE_WE_OUT, CARRY_OUT, HALF_CARRY_FLAG_OUT, ZERO_OUT, POWER_DOWN_FLAG_OUT, WATCHDOG_EXPIRY_FLAG_OUT;
    logic OSC_RUN_OUT, ASLEEP_OUT;
    int errors = 0, compares = 0, cyc = 0;
    rse_exec i_rse_exec (.*);
    // clock and hang guard
    always #50 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            conclude();
        end
    end
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one instruction, sampled after its result edge
    task automatic run(input rse_op_type o, input logic d, input logic [7:0] f, input logic [7:0] k);
        @(posedge CLK_IN);
        EXEC_IN <= 1'b1;
        OP_IN <= o;
        DEST_FILE_IN <= d;
        FILE_DATA_IN <= f;
        LITERAL_IN <= k;
        @(posedge CLK_IN);
        EXEC_IN <= 1'b0;
        #1;
    endtask
    task automatic t_rot;
        run(RSE_OP_ROTATE_LEFT, 1'b0, 8'hE6, 8'h00);
        chk({CARRY_OUT, ACC_OUT}, {1'b1, 8'hCC});
        run(RSE_OP_ROTATE_RIGHT, 1'b1, 8'h02, 8'h00);
        chk(FILE_WDATA_OUT, 8'h81);
        chk({FILE_WE_OUT, CARRY_OUT, ACC_OUT}, {2'b10, 8'hCC});
        run(RSE_OP_ROTATE_LEFT, 1'b1, 8'h80, 8'h00);
        chk({FILE_WE_OUT, CARRY_OUT, FILE_WDATA_OUT, ACC_OUT}, {2'b11, 8'h00, 8'hCC});
        // no operation leaves carry and accumulator alone and drops the file write enable
        run(RSE_OP_NONE, 1'b1, 8'hFF, 8'hFF);
        chk({FILE_WE_OUT, CARRY_OUT, ACC_OUT}, {2'b01, 8'hCC});
        run(RSE_OP_ROTATE_RIGHT, 1'b0, 8'h99, 8'h00);
        chk({FILE_WE_OUT, CARRY_OUT, ACC_OUT}, {2'b01, 8'hCC});
        $display("rotate test done");
    endtask
    task automatic t_sub;
        logic [7:0] ks [5] = '{8'hCC, 8'h07, 8'h00, 8'h18, 8'h0F};
        logic [7:0] m = 8'hCC;
        logic [7:0] r;
        foreach (ks[i]) begin
            r = ks[i] - m;
            run(RSE_OP_LITERAL_MINUS_ACC, 1'b1, 8'h00, ks[i]);
            chk({ACC_OUT, CARRY_OUT, HALF_CARRY_FLAG_OUT}, {r, m <= ks[i], m[3:0] <= ks[i][3:0]});
            chk(ZERO_OUT, r == 8'h00);
            m = r;
        end
        $display("subtract test done");
    endtask
    task automatic t_sleep;
        @(posedge CLK_IN);
        WDT_TICK_IN <= 1'b1;
        // enough ticks to wrap the prescaler once
        repeat (257) @(posedge CLK_IN);
        WDT_TICK_IN <= 1'b0;
        #1;
        chk({WDT_COUNT_OUT, WDT_PRESCALE_OUT}, 16'h0101);
        run(RSE_OP_SLEEP, 1'b0, 8'h00, 8'h00);
        chk({POWER_DOWN_FLAG_OUT, WATCHDOG_EXPIRY_FLAG_OUT, CARRY_OUT, HALF_CARRY_FLAG_OUT, ZERO_OUT}, 5'b01010);
        chk({WDT_COUNT_OUT, WDT_PRESCALE_OUT}, 16'h0000);
        run(RSE_OP_ROTATE_LEFT, 1'b0, 8'h55, 8'h00);
        chk({ASLEEP_OUT, OSC_RUN_OUT, ACC_OUT}, {2'b10, 8'hF0});
        @(posedge CLK_IN);
        WAKE_IN <= 1'b1;
        @(posedge CLK_IN);
        WAKE_IN <= 1'b0;
        #1;
        chk({OSC_RUN_OUT, ASLEEP_OUT}, 2'b10);
        $display("sleep test done");
    endtask
    // verdict
    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge CLK_IN);
        RSTN_IN <= 1'b1;
        #1;
        chk({POWER_DOWN_FLAG_OUT, WATCHDOG_EXPIRY_FLAG_OUT, OSC_RUN_OUT, ACC_OUT}, {3'b111, 8'h00});
        t_rot();
        t_sub();
        t_sleep();
        conclude();
    end
endmodule
bind rse_exec rse_exec_props i_rse_exec_props (.*);
